//--- pkg/aps_map.svh
`ifndef APS_MAP_SVH
`define APS_MAP_SVH

// Register regions, selected by byte address bits [8:6]
`define APS_RGN_CTRL 3'd0
`define APS_RGN_FREQ 3'd1
`define APS_RGN_TIME 3'd2
`define APS_RGN_DIR 3'd3
`define APS_RGN_ACC 3'd4
`define APS_RGN_DEC 3'd5
`define APS_RGN_SHR 3'd6

// Word index inside the control region
`define APS_IDX_CTRL 4'd0
`define APS_IDX_STATUS 4'd1
`define APS_IDX_FREQOUT 4'd2

// Control register fields
`define APS_CTRL_MODE_LSB 0
`define APS_CTRL_INDEP_BIT 4

// Status register fields
`define APS_ST_ACTIVE_BIT 0
`define APS_ST_DONE_BIT 1
`define APS_ST_STAGE_LSB 4
`define APS_ST_DIR_LSB 8

// Ranges: frequency in 0.01 Hz, times in 0.1 s
`define APS_FREQ_MAX 16'hE9FC
`define APS_TIME_MAX 16'hEA60
`define APS_RESET_VAL 16'h0000
`define APS_MODE_RESET 3'h0

// Direction codes
`define APS_DIR_STOP 2'h0
`define APS_DIR_FWD 2'h1
`define APS_DIR_REV 2'h2

// Time base: one tick per 0.1 s
`define APS_CLK_KHZ 20000
`define APS_TICK_MS 100
`define APS_TICK_CYCLES (`APS_CLK_KHZ * `APS_TICK_MS)

`endif

//--- pkg/aps_pkg.sv
package aps_pkg;
    typedef enum logic [1:0] {
        APS_IDLE,
        APS_RUN,
        APS_HOLD,
        APS_DONE
    } aps_state_t;

    typedef logic [2:0] aps_mode_t;
    typedef logic [15:0] aps_word_t;
endpackage

//--- hdl/aps_tick_div.sv
`timescale 1ns/1ps
`default_nettype none

module aps_tick_div #(
    parameter int unsigned CYCLES = 2000000
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Time base control
    input wire logic restart_in,
    output logic tick_out
);
    logic [21:0] cnt_q;
    logic [21:0] cnt_d;
    logic wrap;

    // Wrap at the end of each period; restart aligns the period to a stage start
    assign wrap = (cnt_q == 22'(CYCLES - 1));
    assign cnt_d = (restart_in || wrap) ? 22'h00_0000 : cnt_q + 22'h00_0001;

    // Period counter
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            cnt_q <= 22'h00_0000;
            tick_out <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_out <= wrap && !restart_in;
        end
    end
endmodule

`default_nettype wire

//--- hdl/aps_sequencer.sv
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "aps_map.svh"

module aps_sequencer
    import aps_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `APS_TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Avalon-MM slave
    input wire logic [8:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Drive commands
    input wire logic run_cmd_in,
    input wire logic [3:0] term_speed_sel_in,
    input wire logic [1:0] ramp_set_sel_in,
    input wire logic wobble_active_in,
    input wire logic pid_active_in,
    // Reference to the output stage
    output logic [15:0] freq_ref_out,
    output logic [1:0] dir_out,
    output logic [15:0] accel_time_out,
    output logic [15:0] decel_time_out,
    output logic auto_active_out,
    output logic [3:0] stage_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Merge the two low byte lanes of a write into a 16-bit setting
    function automatic aps_word_t be_merge(input aps_word_t old, input logic [31:0] wd,
                                           input logic [3:0] be);
        aps_word_t res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // Clamp a setting to its programmable range
    function automatic aps_word_t clamp(input aps_word_t v, input aps_word_t lim);
        return (v > lim) ? lim : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    aps_word_t freq_q [16];
    aps_word_t time_q [16];
    logic [1:0] dir_q [16];
    aps_word_t acc_q [16];
    aps_word_t dec_q [16];
    aps_word_t shr_acc_q [4];
    aps_word_t shr_dec_q [4];
    aps_mode_t mode_q;
    logic indep_q;

    aps_state_t state_q;
    logic [3:0] stage_q;
    logic [3:0] resume_q;
    aps_word_t elapsed_q;
    logic ack_q;
    logic [31:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode: one wait cycle, write and read data at the released edge

    logic req;
    logic wr_go;
    logic [2:0] rgn;
    logic [3:0] idx;
    logic [31:0] rd_mux;

    assign req = avs_read_in || avs_write_in;
    assign wr_go = avs_write_in && ack_q;
    assign rgn = avs_address_in[8:6];
    assign idx = avs_address_in[5:2];
    assign avs_waitrequest_out = req && !ack_q;
    assign avs_readdata_out = rdata_q;

    // Handshake and read data capture
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req && !ack_q;
            if (avs_read_in && !ack_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Read selection; unmapped words read as zero, but shared words 4-7 and 12-15 read as aliases of 0-3 and 8-11
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (rgn)
            `APS_RGN_CTRL: begin
                if (idx == `APS_IDX_CTRL) begin
                    rd_mux[`APS_CTRL_MODE_LSB +: 3] = mode_q;
                    rd_mux[`APS_CTRL_INDEP_BIT] = indep_q;
                end else if (idx == `APS_IDX_STATUS) begin
                    rd_mux[`APS_ST_ACTIVE_BIT] = auto_active_out;
                    rd_mux[`APS_ST_DONE_BIT] = (state_q == APS_DONE);
                    rd_mux[`APS_ST_STAGE_LSB +: 4] = stage_out;
                    rd_mux[`APS_ST_DIR_LSB +: 2] = dir_out;
                end else if (idx == `APS_IDX_FREQOUT) begin
                    rd_mux[15:0] = freq_ref_out;
                end
            end
            `APS_RGN_FREQ: rd_mux[15:0] = freq_q[idx];
            `APS_RGN_TIME: rd_mux[15:0] = time_q[idx];
            `APS_RGN_DIR: rd_mux[1:0] = dir_q[idx];
            `APS_RGN_ACC: rd_mux[15:0] = acc_q[idx];
            `APS_RGN_DEC: rd_mux[15:0] = dec_q[idx];
            `APS_RGN_SHR: begin
                if (idx[3]) begin
                    rd_mux[15:0] = shr_dec_q[idx[1:0]];
                end else begin
                    rd_mux[15:0] = shr_acc_q[idx[1:0]];
                end
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Control register
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mode_q <= `APS_MODE_RESET;
            indep_q <= 1'b0;
        end else if (wr_go && rgn == `APS_RGN_CTRL && idx == `APS_IDX_CTRL
                     && avs_byteenable_in[0]) begin
            mode_q <= avs_writedata_in[`APS_CTRL_MODE_LSB +: 3];
            indep_q <= avs_writedata_in[`APS_CTRL_INDEP_BIT];
        end
    end

    // Per-stage tables
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_stage
            logic hit;
            assign hit = wr_go && (idx == 4'(gi));
            always_ff @(posedge mclk_in) begin
                if (sys_rst_in) begin
                    freq_q[gi] <= `APS_RESET_VAL;
                    time_q[gi] <= `APS_RESET_VAL;
                    dir_q[gi] <= `APS_DIR_STOP;
                    acc_q[gi] <= `APS_RESET_VAL;
                    dec_q[gi] <= `APS_RESET_VAL;
                end else if (hit) begin
                    if (rgn == `APS_RGN_FREQ) begin
                        freq_q[gi] <= clamp(be_merge(freq_q[gi], avs_writedata_in,
                            avs_byteenable_in), `APS_FREQ_MAX);
                    end
                    if (rgn == `APS_RGN_TIME) begin
                        time_q[gi] <= clamp(be_merge(time_q[gi], avs_writedata_in,
                            avs_byteenable_in), `APS_TIME_MAX);
                    end
                    if (rgn == `APS_RGN_DIR && avs_byteenable_in[0]) begin
                        dir_q[gi] <= (avs_writedata_in[1:0] == 2'h3) ? `APS_DIR_STOP
                                     : avs_writedata_in[1:0];
                    end
                    if (rgn == `APS_RGN_ACC) begin
                        acc_q[gi] <= clamp(be_merge(acc_q[gi], avs_writedata_in,
                            avs_byteenable_in), `APS_TIME_MAX);
                    end
                    if (rgn == `APS_RGN_DEC) begin
                        dec_q[gi] <= clamp(be_merge(dec_q[gi], avs_writedata_in,
                            avs_byteenable_in), `APS_TIME_MAX);
                    end
                end
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_shared
            logic hit;
            assign hit = wr_go && rgn == `APS_RGN_SHR && idx[1:0] == 2'(gi)
                         && idx[2] == 1'b0;
            always_ff @(posedge mclk_in) begin
                if (sys_rst_in) begin
                    shr_acc_q[gi] <= `APS_RESET_VAL;
                    shr_dec_q[gi] <= `APS_RESET_VAL;
                end else if (hit && !idx[3]) begin
                    shr_acc_q[gi] <= clamp(be_merge(shr_acc_q[gi], avs_writedata_in,
                        avs_byteenable_in), `APS_TIME_MAX);
                end else if (hit && idx[3]) begin
                    shr_dec_q[gi] <= clamp(be_merge(shr_dec_q[gi], avs_writedata_in,
                        avs_byteenable_in), `APS_TIME_MAX);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    logic any_time;
    logic auto_en;
    logic resume_mode;
    logic single_mode;
    logic hold_mode;
    logic tick;
    logic stage_end;
    logic restart;
    logic running;

    // Any nonzero run time makes the program usable
    always_comb begin
        any_time = 1'b0;
        for (int i = 0; i < 16; i++) begin
            any_time = any_time || (time_q[i] != `APS_RESET_VAL);
        end
    end

    assign auto_en = (mode_q != 3'h0) && (mode_q <= 3'h6)
                     && !wobble_active_in && !pid_active_in
                     && any_time;
    assign resume_mode = (mode_q <= 3'h3);
    assign single_mode = (mode_q == 3'h1) || (mode_q == 3'h4);
    assign hold_mode = (mode_q == 3'h3) || (mode_q == 3'h6);
    assign running = (state_q == APS_RUN);
    assign stage_end = running && tick && (elapsed_q + 16'h0001 >= time_q[stage_q]);
    assign restart = (state_q == APS_IDLE) || stage_end;

    aps_tick_div #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .restart_in(restart),
        .tick_out(tick)
    );

    // Stage state machine
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_q <= APS_IDLE;
            stage_q <= 4'h0;
            resume_q <= 4'h0;
            elapsed_q <= `APS_RESET_VAL;
        end else begin
            case (state_q)
                APS_IDLE: begin
                    elapsed_q <= `APS_RESET_VAL;
                    if (run_cmd_in && auto_en) begin
                        state_q <= APS_RUN;
                        stage_q <= resume_mode ? resume_q : 4'h0;
                    end
                end
                APS_RUN: begin
                    if (!run_cmd_in || !auto_en) begin
                        state_q <= APS_IDLE;
                        resume_q <= stage_q;
                    end else if (stage_end) begin
                        elapsed_q <= `APS_RESET_VAL;
                        if (stage_q != 4'hF) begin
                            stage_q <= stage_q + 4'h1;
                        end else if (single_mode) begin
                            state_q <= APS_DONE;
                        end else if (hold_mode) begin
                            state_q <= APS_HOLD;
                        end else begin
                            stage_q <= 4'h0;
                        end
                    end else if (tick) begin
                        elapsed_q <= elapsed_q + 16'h0001;
                    end
                end
                APS_HOLD: begin
                    if (!run_cmd_in || !auto_en) begin
                        state_q <= APS_IDLE;
                        resume_q <= 4'h0;
                    end
                end
                APS_DONE: begin
                    if (!run_cmd_in || !auto_en) begin
                        state_q <= APS_IDLE;
                        resume_q <= 4'h0;
                    end
                end
                default: state_q <= APS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference outputs

    logic auto_on;
    logic [3:0] act_stage;
    aps_word_t freq_sel;
    logic [1:0] dir_sel;

    assign auto_on = (state_q == APS_RUN) || (state_q == APS_HOLD);
    assign act_stage = auto_on ? stage_q : term_speed_sel_in;
    assign dir_sel = auto_on ? dir_q[act_stage]
                     : (run_cmd_in ? `APS_DIR_FWD : `APS_DIR_STOP);
    assign freq_sel = (dir_sel == `APS_DIR_STOP || state_q == APS_DONE)
                      ? `APS_RESET_VAL : freq_q[act_stage];

    // Registered reference to the output stage
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            freq_ref_out <= `APS_RESET_VAL;
            dir_out <= `APS_DIR_STOP;
            accel_time_out <= `APS_RESET_VAL;
            decel_time_out <= `APS_RESET_VAL;
            auto_active_out <= 1'b0;
            stage_out <= 4'h0;
        end else begin
            freq_ref_out <= (state_q == APS_DONE) ? `APS_RESET_VAL : freq_sel;
            dir_out <= (state_q == APS_DONE) ? `APS_DIR_STOP : dir_sel;
            accel_time_out <= indep_q ? acc_q[act_stage]
                              : shr_acc_q[ramp_set_sel_in];
            decel_time_out <= indep_q ? dec_q[act_stage]
                              : shr_dec_q[ramp_set_sel_in];
            auto_active_out <= auto_on;
            stage_out <= act_stage;
        end
    end
endmodule

`default_nettype wire

//--- dv/aps_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none

module aps_seq_sva #(
    parameter int unsigned TICK_CYCLES = 10
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Bus handshake
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    // Commands
    input wire logic run_cmd_in,
    input wire logic [3:0] term_speed_sel_in,
    input wire logic wobble_active_in,
    input wire logic pid_active_in,
    // Reference outputs
    input wire logic [15:0] freq_ref_out,
    input wire logic [1:0] dir_out,
    input wire logic auto_active_out,
    input wire logic [3:0] stage_out
);
    int dwell_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    // Cycles since the stage index last moved
    always_ff @(posedge mclk_in) begin
        dwell_q <= (sys_rst_in || $changed(stage_out)) ? 0 : dwell_q + 1;
    end

    sequence s_wait_one;
        avs_waitrequest_out ##1 !avs_waitrequest_out;
    endsequence

    chk_bus_wait_one: assert property ($rose(avs_read_in || avs_write_in) |-> s_wait_one)
        else $error("waitrequest not one cycle");
    chk_reset_zero: assert property ($fell(sys_rst_in) |-> freq_ref_out == 16'h0000
        && !auto_active_out && stage_out == 4'h0) else $error("outputs not cleared");
    chk_freq_range: assert property (freq_ref_out <= 16'hE9FC)
        else $error("frequency above range");
    chk_dir_code: assert property (dir_out != 2'h3)
        else $error("illegal direction code");
    chk_stop_zero: assert property (auto_active_out && dir_out == 2'h0 |-> freq_ref_out == 0)
        else $error("stop stage drives frequency");
    chk_inhibit_off: assert property (wobble_active_in || pid_active_in |-> ##[1:3] !auto_active_out)
        else $error("auto not inhibited");
    chk_run_drop: assert property (!run_cmd_in |-> ##[1:3] !auto_active_out)
        else $error("auto survives run drop");
    chk_stage_step: assert property ($changed(stage_out) && auto_active_out
        && $past(auto_active_out) |-> stage_out == $past(stage_out) + 4'd1)
        else $error("stage skipped");
    chk_stage_dwell: assert property ($changed(stage_out) && auto_active_out
        && $past(auto_active_out) |-> dwell_q + 1 >= TICK_CYCLES)
        else $error("stage too short");
    chk_term_follow: assert property ((!auto_active_out && !run_cmd_in
        && $stable(term_speed_sel_in))[*3] |-> stage_out == term_speed_sel_in)
        else $error("terminal select not followed");
endmodule

bind aps_sequencer aps_seq_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out), .run_cmd_in(run_cmd_in),
    .term_speed_sel_in(term_speed_sel_in), .wobble_active_in(wobble_active_in),
    .pid_active_in(pid_active_in), .freq_ref_out(freq_ref_out), .dir_out(dir_out),
    .auto_active_out(auto_active_out), .stage_out(stage_out));

`default_nettype wire

//--- dv/aps_drive_partner.sv
`timescale 1ns/1ps
`default_nettype none

module aps_drive_partner (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Operator side
    input wire logic run_req_in,
    output logic run_cmd_out,
    // Motor stage side
    input wire logic [15:0] freq_ref_in,
    input wire logic [1:0] dir_in,
    output logic rev_seen_out
);
    logic run_q;
    logic rev_q;

    assign run_cmd_out = run_q;
    assign rev_seen_out = rev_q;

    // Run switch latched at the edge; motor notes any reverse drive
    always_ff @(posedge mclk_in) begin
        run_q <= sys_rst_in ? 1'b0 : run_req_in;
        rev_q <= sys_rst_in ? 1'b0 : (rev_q || (dir_in == 2'h2 && freq_ref_in != 16'h0000));
    end
endmodule

`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import aps_pkg::*;
    typedef struct {logic [8:0] a; logic [31:0] d; logic [31:0] e;} aps_row_t;
    logic mclk_in = 0, sys_rst_in = 1, rd = 0, wr = 0, wq, run_req = 0, run_cmd;
    logic wob = 0, pid = 0, act, rev;
    logic [8:0] adr = 9'h000;
    logic [31:0] wd = 32'h0000_0000, rdata, q;
    logic [3:0] term = 4'h0, stg;
    logic [15:0] freq, acc, dec;
    logic [1:0] dir;
    logic [1:0] rsel = 2'h0;
    int num_errors = 0, checked = 0, cyc = 0;
    aps_row_t rows [8] = '{'{9'h040, 32'h0000_E9FC, 32'h0000_E9FC},
        '{9'h040, 32'h0000_FFFF, 32'h0000_E9FC}, '{9'h0BC, 32'h0000_FFFF, 32'h0000_EA60},
        '{9'h13C, 32'h0000_EA60, 32'h0000_EA60}, '{9'h17C, 32'h0000_FFFF, 32'h0000_EA60},
        '{9'h0C0, 32'h0000_0003, 32'h0000_0000}, '{9'h0C4, 32'h0000_0002, 32'h0000_0002},
        '{9'h1C0, 32'h0000_1234, 32'h0000_0000}};

    aps_sequencer #(.TICK_CYCLES(10)) i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wq),
        .run_cmd_in(run_cmd), .term_speed_sel_in(term), .ramp_set_sel_in(rsel),
        .wobble_active_in(wob), .pid_active_in(pid), .freq_ref_out(freq), .dir_out(dir),
        .accel_time_out(acc), .decel_time_out(dec), .auto_active_out(act), .stage_out(stg));
    aps_drive_partner i_far (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .run_req_in(run_req),
        .run_cmd_out(run_cmd), .freq_ref_in(freq), .dir_in(dir), .rev_seen_out(rev));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        forever #25 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus, compare and wait helpers
    task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        @(posedge mclk_in);
        // Hold the request until waitrequest is sampled low at a rising edge
        while (wq !== 1'b0) begin
            @(posedge mclk_in);
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic wait_stage(input logic [3:0] s);
        int n;
        n = 0;
        while (stg !== s && n < 3000) begin
            @(posedge mclk_in);
            n++;
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        bus(0, 9'h000, 0);
        chk("ctrl reset", 32'h0000_0000, q);
        foreach (rows[i]) begin
            bus(1, rows[i].a, rows[i].d);
            bus(0, rows[i].a, 0);
            chk("setting", rows[i].e, q);
        end
        $display("test table done");
        for (int i = 0; i < 16; i++) begin
            bus(1, 9'h040 + 9'(4 * i), 32'(100 * (i + 1)));
            bus(1, 9'h080 + 9'(4 * i), 0);
            bus(1, 9'h0C0 + 9'(4 * i), (i == 15) ? 32'h0000_0002 : 32'h0000_0001);
            bus(1, 9'h100 + 9'(4 * i), 32'(10 + i));
            bus(1, 9'h140 + 9'(4 * i), 32'(20 + i));
        end
        bus(1, 9'h000, 32'h0000_0011);
        term <= 4'h9;
        run_req <= 1'b1;
        cycles(40);
        chk("zero times idle", 0, act);
        run_req <= 1'b0;
        bus(1, 9'h080, 32'h0000_0001);
        $display("test zero time done");
        for (int m = 1; m <= 6; m++) begin
            bus(1, 9'h000, 32'(16 + m));
            run_req <= 1'b1;
            wait_stage(4'h3);
            cycles(2);
            chk("stage", 4'h3, stg);
            chk("freq", 400, freq);
            chk("dir", 2'h1, dir);
            chk("accel", 13, acc);
            chk("decel", 23, dec);
            run_req <= 1'b0;
            cycles(10);
            chk("dropped", 0, act);
            run_req <= 1'b1;
            cycles(5);
            chk("restart", (m < 4) ? 4'h3 : 4'h0, stg);
            wait_stage(4'hF);
            cycles(30);
            chk("after pass", (m % 3 != 1), act);
            if (m % 3 == 1) chk("done freq", 0, freq);
            if (m % 3 == 0) chk("hold stage", 4'hF, stg);
            if (m % 3 == 0) chk("hold freq", 1600, freq);
            if (m % 3 == 0) chk("hold rev", 1, rev);
            run_req <= 1'b0;
            cycles(10);
            $display("test mode %0d done", m);
        end
        bus(1, 9'h000, 32'h0000_0002);
        bus(1, 9'h188, 32'h0000_0055);
        bus(1, 9'h1A8, 32'h0000_0066);
        rsel <= 2'h2;
        run_req <= 1'b1;
        cycles(20);
        wob <= 1'b1;
        cycles(5);
        chk("wobble", 0, act);
        wob <= 1'b0;
        pid <= 1'b1;
        cycles(5);
        chk("pid", 0, act);
        pid <= 1'b0;
        cycles(5);
        chk("resumed", 1, act);
        chk("shared accel", 32'h0000_0055, acc);
        chk("shared decel", 32'h0000_0066, dec);
        bus(1, 9'h000, 32'h0000_0010);
        cycles(5);
        chk("mode zero", 0, act);
        bus(0, 9'h004, 0);
        chk("status active", 0, q[0]);
        $display("test inhibit done");
        bus(1, 9'h000, 32'h0000_0012);
        cycles(30);
        sys_rst_in <= 1'b1;
        cycles(2);
        chk("rst freq", 0, freq);
        chk("rst active", 0, act);
        sys_rst_in <= 1'b0;
        run_req <= 1'b0;
        bus(0, 9'h000, 0);
        chk("rst ctrl", 32'h0000_0000, q);
        $display("test reset done");
        wrap_up();
    end
endmodule

`default_nettype wire
